// ===== fpe_pkg.sv
// Constants and types for the flash program/erase sequencer
package fpe_pkg;

  // ==========================================================
  // Clock and counter widths
  // ==========================================================
  localparam int CLK_NS  = 100;
  localparam int TMR_W   = 17;
  localparam int PASS_W  = 9;

  // ==========================================================
  // Wait times in nanoseconds
  // ==========================================================
  localparam int T_SWE_NS     = 10_000;
  localparam int T_PSU_NS     = 50_000;
  localparam int T_P_SHORT_NS = 150_000;
  localparam int T_P_LONG_NS  = 500_000;
  localparam int T_PCLR_NS    = 10_000;
  localparam int T_SCLR_NS    = 10_000;
  localparam int T_PV_NS      = 4_000;
  localparam int T_DUMMY_NS   = 2_000;
  localparam int T_PVCLR_NS   = 4_000;
  localparam int T_ESU_NS     = 200_000;
  localparam int T_E_SHORT_NS = 5_000_000;
  localparam int T_E_LONG_NS  = 10_000_000;
  localparam int T_EV_NS      = 20_000;
  localparam int T_EVCLR_NS   = 5_000;

  // ==========================================================
  // Cycle counts, least times rounded up
  // ==========================================================
  localparam int CYC_SWE     = (T_SWE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PSU     = (T_PSU_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_P_SHORT = (T_P_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_P_LONG  = (T_P_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PCLR    = (T_PCLR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SCLR    = (T_SCLR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PV      = (T_PV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_DUMMY   = (T_DUMMY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_PVCLR   = (T_PVCLR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_ESU     = (T_ESU_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_E_SHORT = (T_E_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_E_LONG  = (T_E_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_EV      = (T_EV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_EVCLR   = (T_EVCLR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SAMPLE  = 6;

  // ==========================================================
  // Pass limits
  // ==========================================================
  localparam int P_SHORT_PASSES = 4;
  localparam int P_MAX_PASSES   = 403;
  localparam int E_SHORT_PASSES = 60;
  localparam int E_LONG_PASSES  = 30;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SWE, ST_SETUP, ST_PULSE, ST_PCLR,
    ST_SCLR, ST_VSET, ST_DUMMY, ST_READ, ST_VCLR
  } fpe_state_t;

endpackage : fpe_pkg

// ===== fpe_seq_if.sv
// Timer and pass-counter signals between the sequencer modules
`timescale 1ns/100ps
`default_nettype none
interface fpe_seq_if #(
  parameter int TW = fpe_pkg::TMR_W,
  parameter int PW = fpe_pkg::PASS_W
);
  logic          load;
  logic [TW-1:0] load_val;
  logic          expired;
  logic          pass_clr;
  logic          pass_inc;
  logic [PW-1:0] pass_cnt;

  modport ctl (output load, load_val, pass_clr, pass_inc,
               input  expired, pass_cnt);
  modport tmr (input  load, load_val, output expired);
  modport cnt (input  pass_clr, pass_inc, output pass_cnt);
endinterface : fpe_seq_if
`default_nettype wire

// ===== fpe_wait_timer.sv
// Down-counting wait timer
`timescale 1ns/100ps
`default_nettype none
module fpe_wait_timer #(
  parameter int TW = fpe_pkg::TMR_W
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  fpe_seq_if.tmr    sif
);
  logic [TW-1:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (sif.load) begin
      cnt_q <= sif.load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - TW'(1);
    end
  end

  // Masked during load so a stale zero is never taken
  assign sif.expired = (cnt_q == '0) && !sif.load;
endmodule : fpe_wait_timer
`default_nettype wire

// ===== fpe_pass_counter.sv
// Pass counter for the pulse-and-verify loop
`timescale 1ns/100ps
`default_nettype none
module fpe_pass_counter #(
  parameter int PW = fpe_pkg::PASS_W
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  fpe_seq_if.cnt    sif
);
  logic [PW-1:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || sif.pass_clr) begin
      cnt_q <= '0;
    end else if (sif.pass_inc && cnt_q != '1) begin
      cnt_q <= cnt_q + PW'(1);
    end
  end

  assign sif.pass_cnt = cnt_q;
endmodule : fpe_pass_counter
`default_nettype wire

// ===== fpe_flash_seq.sv
// Program/erase timing sequencer driving the flash control bits
`timescale 1ns/100ps
`default_nettype none
// Flash program/erase rules
// R1: After setting write enable, wait at least 10 us before the next step.
// R2: After program setup set, wait at least 50 us before program pulse.
// R3: Program pulse lasts 150 us on passes 1-4, 500 us on later passes.
// R4: After clearing program pulse, wait 10 us before clearing setup.
// R5: After clearing program setup, wait 10 us before program verify.
// R6: After setting program verify, wait 4 us before the dummy write.
// R7: After the all-ones dummy write, wait 2 us before reading back.
// R8: After clearing program verify, wait 4 us before next pass or end.
// R9: At most 403 program passes; still failing afterwards means failure.
// R10: Device programs 32-byte units; only pulse time counts as program time.
// R11: After erase setup set, wait at least 200 us before erase pulse.
// R12: Erase pulse lasts a chosen 5 ms or 10 ms each pass.
// R13: Erase pass limit 60 for 5 ms pulses, 30 for 10 ms pulses.
// R14: After clearing erase pulse, wait 10 us before clearing setup.
// R15: After clearing erase setup, wait 10 us before erase verify.
// R16: After setting erase verify, wait 20 us before the dummy write.
// R17: After clearing erase verify, wait 5 us before next pass or end.
// R18: Device erases one whole block; only pulse time counts as erase time.
// R19: Program pass: setup, pulse, clear both, verify, write, read, clear.
// R20: Erase pass in same order; write enable cleared when operation ends.
module fpe_flash_seq #(
  parameter int TW          = fpe_pkg::TMR_W,
  parameter int PW          = fpe_pkg::PASS_W,
  parameter int CYC_P_LONG  = fpe_pkg::CYC_P_LONG,
  parameter int CYC_E_SHORT = fpe_pkg::CYC_E_SHORT,
  parameter int CYC_E_LONG  = fpe_pkg::CYC_E_LONG
) (
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          start_in,
  input  wire logic          erase_in,
  input  wire logic          erase_long_in,
  input  wire logic          verify_ok_in,
  output logic               busy_out,
  output logic               done_out,
  output logic               fail_out,
  output logic [PW-1:0]      passes_out,
  output logic               software_write_enable_out,
  output logic               program_setup_out,
  output logic               program_pulse_out,
  output logic               program_verify_out,
  output logic               erase_setup_out,
  output logic               erase_pulse_out,
  output logic               erase_verify_out,
  output logic               dummy_write_out,
  output logic               verify_read_out
);

  // ==========================================================
  // Submodules
  // ==========================================================
  fpe_seq_if #(.TW(TW), .PW(PW)) sif ();

  fpe_wait_timer #(.TW(TW)) u_timer (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .sif      (sif)
  );

  fpe_pass_counter #(.PW(PW)) u_passes (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .sif      (sif)
  );

  // ==========================================================
  // Verify pin synchroniser
  // ==========================================================
  logic ok_s1_q;
  logic ok_s2_q;
  logic ok_s3_q;
  logic ok_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ok_s1_q <= 1'b0;
      ok_s2_q <= 1'b0;
      ok_s3_q <= 1'b0;
      ok_q    <= 1'b0;
    end else begin
      ok_s1_q <= verify_ok_in;
      ok_s2_q <= ok_s1_q;
      ok_s3_q <= ok_s2_q;
      if (ok_s2_q == ok_s3_q) begin
        ok_q <= ok_s3_q;
      end
    end
  end

  // ==========================================================
  // Wait and limit selection
  // ==========================================================
  fpe_pkg::fpe_state_t state_q;
  logic                erase_q;
  logic                long_q;
  logic                load_q;
  logic [TW-1:0]       load_val_q;
  logic                clr_q;
  logic                inc_q;
  logic [TW-1:0]       w_setup;
  logic [TW-1:0]       w_pulse;
  logic [TW-1:0]       w_verify;
  logic [TW-1:0]       w_vclr;
  logic [PW-1:0]       pass_limit;
  logic                last_pass;

  always_comb begin
    if (erase_q) begin
      w_setup  = TW'(fpe_pkg::CYC_ESU);                     // R11
      w_pulse  = long_q ? TW'(CYC_E_LONG) : TW'(CYC_E_SHORT); // R12
      w_verify = TW'(fpe_pkg::CYC_EV);                      // R16
      w_vclr   = TW'(fpe_pkg::CYC_EVCLR);                   // R17
      pass_limit = long_q ? PW'(fpe_pkg::E_LONG_PASSES)
                          : PW'(fpe_pkg::E_SHORT_PASSES);   // R13
    end else begin
      w_setup  = TW'(fpe_pkg::CYC_PSU);                     // R2
      w_pulse  = (sif.pass_cnt <= PW'(fpe_pkg::P_SHORT_PASSES))
               ? TW'(fpe_pkg::CYC_P_SHORT) : TW'(CYC_P_LONG); // R3
      w_verify = TW'(fpe_pkg::CYC_PV);                      // R6
      w_vclr   = TW'(fpe_pkg::CYC_PVCLR);                   // R8
      pass_limit = PW'(fpe_pkg::P_MAX_PASSES);              // R9
    end
    last_pass = (sif.pass_cnt >= pass_limit);
  end

  assign sif.load     = load_q;
  assign sif.load_val = load_val_q;
  assign sif.pass_clr = clr_q;
  assign sif.pass_inc = inc_q;

  // ==========================================================
  // Sequencer
  // ==========================================================
  logic setup_q;
  logic pulse_q;
  logic verify_q;
  logic swe_q;
  logic dw_q;
  logic rd_q;
  logic match_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q    <= fpe_pkg::ST_IDLE;
      erase_q    <= 1'b0;
      long_q     <= 1'b0;
      load_q     <= 1'b0;
      load_val_q <= '0;
      clr_q      <= 1'b0;
      inc_q      <= 1'b0;
      swe_q      <= 1'b0;
      setup_q    <= 1'b0;
      pulse_q    <= 1'b0;
      verify_q   <= 1'b0;
      dw_q       <= 1'b0;
      rd_q       <= 1'b0;
      match_q    <= 1'b0;
      done_out   <= 1'b0;
      fail_out   <= 1'b0;
    end else begin
      load_q   <= 1'b0;
      clr_q    <= 1'b0;
      inc_q    <= 1'b0;
      dw_q     <= 1'b0;
      rd_q     <= 1'b0;
      done_out <= 1'b0;
      case (state_q)
        fpe_pkg::ST_IDLE: begin
          if (start_in) begin
            erase_q    <= erase_in;
            long_q     <= erase_long_in;
            fail_out   <= 1'b0;
            swe_q      <= 1'b1;
            clr_q      <= 1'b1;
            load_q     <= 1'b1;
            load_val_q <= TW'(fpe_pkg::CYC_SWE);            // R1
            state_q    <= fpe_pkg::ST_SWE;
          end
        end
        fpe_pkg::ST_SWE: begin
          if (sif.expired) begin
            setup_q    <= 1'b1;                             // R19 R20
            inc_q      <= 1'b1;
            load_q     <= 1'b1;
            load_val_q <= w_setup;
            state_q    <= fpe_pkg::ST_SETUP;
          end
        end
        fpe_pkg::ST_SETUP: begin
          if (sif.expired) begin
            pulse_q    <= 1'b1;
            load_q     <= 1'b1;
            load_val_q <= w_pulse;
            state_q    <= fpe_pkg::ST_PULSE;
          end
        end
        fpe_pkg::ST_PULSE: begin
          if (sif.expired) begin
            pulse_q    <= 1'b0;
            load_q     <= 1'b1;
            load_val_q <= erase_q ? TW'(fpe_pkg::CYC_PCLR)    // R14
                                  : TW'(fpe_pkg::CYC_PCLR);   // R4
            state_q    <= fpe_pkg::ST_PCLR;
          end
        end
        fpe_pkg::ST_PCLR: begin
          if (sif.expired) begin
            setup_q    <= 1'b0;
            load_q     <= 1'b1;
            load_val_q <= TW'(fpe_pkg::CYC_SCLR);           // R5 R15
            state_q    <= fpe_pkg::ST_SCLR;
          end
        end
        fpe_pkg::ST_SCLR: begin
          if (sif.expired) begin
            verify_q   <= 1'b1;
            load_q     <= 1'b1;
            load_val_q <= w_verify;
            state_q    <= fpe_pkg::ST_VSET;
          end
        end
        fpe_pkg::ST_VSET: begin
          if (sif.expired) begin
            dw_q       <= 1'b1;
            load_q     <= 1'b1;
            load_val_q <= TW'(fpe_pkg::CYC_DUMMY);          // R7
            state_q    <= fpe_pkg::ST_DUMMY;
          end
        end
        fpe_pkg::ST_DUMMY: begin
          if (sif.expired) begin
            rd_q       <= 1'b1;
            load_q     <= 1'b1;
            load_val_q <= TW'(fpe_pkg::CYC_SAMPLE);
            state_q    <= fpe_pkg::ST_READ;
          end
        end
        fpe_pkg::ST_READ: begin
          if (sif.expired) begin
            match_q    <= ok_q;
            verify_q   <= 1'b0;
            load_q     <= 1'b1;
            load_val_q <= w_vclr;
            state_q    <= fpe_pkg::ST_VCLR;
          end
        end
        fpe_pkg::ST_VCLR: begin
          if (sif.expired) begin
            if (match_q || last_pass) begin
              swe_q    <= 1'b0;                             // R20
              done_out <= match_q;
              fail_out <= !match_q;                         // R9
              state_q  <= fpe_pkg::ST_IDLE;
            end else begin
              setup_q    <= 1'b1;                           // R19
              inc_q      <= 1'b1;
              load_q     <= 1'b1;
              load_val_q <= w_setup;
              state_q    <= fpe_pkg::ST_SETUP;
            end
          end
        end
        default: begin
          state_q <= fpe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Output registers
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      busy_out                  <= 1'b0;
      passes_out                <= '0;
      software_write_enable_out <= 1'b0;
      program_setup_out         <= 1'b0;
      program_pulse_out         <= 1'b0;
      program_verify_out        <= 1'b0;
      erase_setup_out           <= 1'b0;
      erase_pulse_out           <= 1'b0;
      erase_verify_out          <= 1'b0;
      dummy_write_out           <= 1'b0;
      verify_read_out           <= 1'b0;
    end else begin
      busy_out                  <= (state_q != fpe_pkg::ST_IDLE);
      passes_out                <= sif.pass_cnt;
      software_write_enable_out <= swe_q;
      program_setup_out         <= setup_q && !erase_q;
      program_pulse_out         <= pulse_q && !erase_q;
      program_verify_out        <= verify_q && !erase_q;
      erase_setup_out           <= setup_q && erase_q;
      erase_pulse_out           <= pulse_q && erase_q;
      erase_verify_out          <= verify_q && erase_q;
      dummy_write_out           <= dw_q;
      verify_read_out           <= rd_q;
    end
  end

  // ==========================================================
  // Checks on output spacing
  // ==========================================================
  logic [6:0]    bits_now;
  logic [6:0]    bits_last_q;
  logic [TW-1:0] hold_q;
  logic [TW-1:0] dw_age_q;

  assign bits_now = {software_write_enable_out, program_setup_out,
                     program_pulse_out, program_verify_out,
                     erase_setup_out, erase_pulse_out, erase_verify_out};

  always_ff @(posedge clk_in) begin
    bits_last_q <= bits_now;
    if (bits_now != bits_last_q) begin
      hold_q <= TW'(1);
    end else if (hold_q != '1) begin
      hold_q <= hold_q + TW'(1);
    end
    if (dummy_write_out) begin
      dw_age_q <= TW'(1);
    end else if (dw_age_q != '1) begin
      dw_age_q <= dw_age_q + TW'(1);
    end
  end

  a_psu_to_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(program_pulse_out) |-> hold_q >= TW'(fpe_pkg::CYC_PSU)) // R2
    else $error("program pulse set too early after setup");
  a_pulse_width: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(program_pulse_out) && passes_out <= PW'(fpe_pkg::P_SHORT_PASSES)
    |-> hold_q >= TW'(fpe_pkg::CYC_P_SHORT) &&
        hold_q <= TW'(fpe_pkg::CYC_P_SHORT + 2)) // R3
    else $error("short program pulse length wrong");
  a_pclr_to_sclr: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(program_setup_out) |-> hold_q >= TW'(fpe_pkg::CYC_PCLR)) // R4
    else $error("program setup cleared too soon");
  a_sclr_to_pv: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(program_verify_out) |-> hold_q >= TW'(fpe_pkg::CYC_SCLR)) // R5
    else $error("program verify set too soon");
  a_pv_to_dummy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    dummy_write_out && program_verify_out
    |-> hold_q >= TW'(fpe_pkg::CYC_PV)) // R6
    else $error("dummy write too soon after verify set");
  a_dummy_to_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    verify_read_out |-> dw_age_q >= TW'(fpe_pkg::CYC_DUMMY)) // R7
    else $error("read back too soon after dummy write");
  a_esu_to_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(erase_pulse_out) |-> hold_q >= TW'(fpe_pkg::CYC_ESU)) // R11
    else $error("erase pulse set too early after setup");
  a_erase_width: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(erase_pulse_out) |-> hold_q >= TW'(CYC_E_SHORT) &&
                               hold_q <= TW'(CYC_E_LONG + 2)) // R12
    else $error("erase pulse length out of range");
  a_fail_limit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(fail_out) |-> passes_out == pass_limit) // R9
    else $error("failure flagged before pass limit");
  a_swe_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(done_out) |-> ##1 !software_write_enable_out) // R20
    else $error("write enable still set after end");

endmodule : fpe_flash_seq
`default_nettype wire

// ===== fpe_flash_model.sv
// Behavioural flash device answering the verify read-back
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_model (
  input  wire logic       clk_in,
  input  wire logic       sw_en_in,
  input  wire logic       pulse_in,
  input  wire logic       read_in,
  input  wire logic [8:0] need_in,
  input  wire logic [1:0] delay_in,
  output logic            ok_out
);
  int   passes    = 0;
  int   pulse_cyc = 0;
  int   wait_c    = 0;
  logic ans       = 1'b0;
  logic ans_now;

  initial ok_out = 1'b0;

  assign ans_now = need_in != 9'h000 && passes + 1 >= int'(need_in);

  // ==========================================================
  // Pass and pulse-time tally, cleared when writing is disabled
  // ==========================================================
  always @(posedge clk_in) begin
    if (!sw_en_in) begin
      passes    <= 0;
      pulse_cyc <= 0;
    end else begin
      if (read_in)
        passes <= passes + 1;
      if (pulse_in)
        pulse_cyc <= pulse_cyc + 1;
    end
  end

  // ==========================================================
  // Verify answer, stale value inverted until the answer lands
  // ==========================================================
  always @(posedge clk_in) begin
    if (read_in) begin
      ans    <= ans_now;
      wait_c <= int'(delay_in);
      ok_out <= (delay_in == 2'h0) ? ans_now : ~ok_out;
    end else if (wait_c > 0) begin
      wait_c <= wait_c - 1;
      if (wait_c == 1)
        ok_out <= ans;
    end
  end
endmodule : fpe_flash_model
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int PL = 50;
  localparam int ES = 100;
  localparam int EL = 200;
  logic       clk_in        = 1'b0;
  logic       rst_b_in      = 1'b0;
  logic       start_in      = 1'b0;
  logic       erase_in      = 1'b0;
  logic       erase_long_in = 1'b0;
  logic [8:0] need          = 9'h000;
  logic [1:0] delay         = 2'h0;
  logic [8:0] passes;
  logic       ok, busy, done, fail, sw_en, dwr, vrd;
  logic       p_set, p_pul, p_ver, e_set, e_pul, e_ver;
  logic       su_q = 1'b0, pl_q = 1'b0, vf_q = 1'b0, sw_q = 1'b0;
  int         bad_count = 0, n_checks = 0, seed = 99689;
  int         cyc = 0, last = 0, pn = 0, gap, pw, i;
  wire logic  su = p_set | e_set;
  wire logic  pl = p_pul | e_pul;
  wire logic  vf = p_ver | e_ver;

  always #50 clk_in = ~clk_in;

  fpe_flash_seq #(
    .CYC_P_LONG  (PL),
    .CYC_E_SHORT (ES),
    .CYC_E_LONG  (EL)
  ) i_dut (
    .clk_in                    (clk_in),
    .rst_b_in                  (rst_b_in),
    .start_in                  (start_in),
    .erase_in                  (erase_in),
    .erase_long_in             (erase_long_in),
    .verify_ok_in              (ok),
    .busy_out                  (busy),
    .done_out                  (done),
    .fail_out                  (fail),
    .passes_out                (passes),
    .software_write_enable_out (sw_en),
    .program_setup_out         (p_set),
    .program_pulse_out         (p_pul),
    .program_verify_out        (p_ver),
    .erase_setup_out           (e_set),
    .erase_pulse_out           (e_pul),
    .erase_verify_out          (e_ver),
    .dummy_write_out           (dwr),
    .verify_read_out           (vrd)
  );

  fpe_flash_model i_flash (
    .clk_in   (clk_in),
    .sw_en_in (sw_en),
    .pulse_in (pl),
    .read_in  (vrd),
    .need_in  (need),
    .delay_in (delay),
    .ok_out   (ok)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  function automatic int exp_passes(input logic e, input logic l,
                                    input int nd);
    if (nd != 0)
      return nd;
    return e ? (l ? 30 : 60) : 403;
  endfunction : exp_passes

  // Total pulse cycles the device sees over np passes
  function automatic int exp_pulse(input logic e, input logic l,
                                   input int np);
    int t = 0;
    for (int k = 1; k <= np; k++)
      t += (e ? (l ? EL : ES) : (k <= 4 ? fpe_pkg::CYC_P_SHORT : PL)) + 2;
    return t;
  endfunction : exp_pulse

  // ==========================================================
  // Step spacing and order monitor
  // ==========================================================
  always @(negedge clk_in) begin
    cyc = cyc + 1;
    gap = cyc - last;
    if (su && !su_q) begin
      pn = pn + 1;
      if (pn == 1)
        check(gap >= 100, 1);
      else
        check(gap >= (erase_in ? 50 : 40), 1);
    end
    if (pl && !pl_q)
      check(su && gap >= (erase_in ? 2000 : 500), 1);
    if (!pl && pl_q) begin
      pw = erase_in ? (erase_long_in ? EL : ES) : (pn <= 4 ? 1500 : PL);
      check(gap >= pw && gap <= pw + 2, 1);
    end
    if (!su && su_q)
      check(!pl && gap >= 100, 1);
    if (vf && !vf_q)
      check(!su && gap >= 100, 1);
    if (dwr) begin
      check(vf && gap >= (erase_in ? 200 : 40), 1);
      check(erase_in ? {p_set,p_pul,p_ver} : {e_set,e_pul,e_ver}, 0);
    end
    if (vrd)
      check(vf && gap >= 20, 1);
    if (!sw_en && sw_q)
      check(!su && !vf && gap >= (erase_in ? 50 : 40), 1);
    if (su != su_q || pl != pl_q || vf != vf_q || sw_en != sw_q || dwr || vrd)
      last = cyc;
    {su_q, pl_q, vf_q, sw_q} = {su, pl, vf, sw_en};
  end

  // One whole operation; poke retries start while busy
  task automatic run_op(input logic e, input logic l, input int nd,
                        input logic poke);
    int n;
    n = 0;
    @(negedge clk_in);
    erase_in      = e;
    erase_long_in = l;
    need          = nd[8:0];
    // Answer must land early enough to clear the 3-stage sync before sampling
    delay         = 2'({$random(seed)} % 2);
    start_in      = 1'b1;
    pn            = 0;
    @(negedge clk_in);
    start_in = 1'b0;
    while (busy !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    check({busy, sw_en, fail}, 3'h6);
    n = 0;
    while (done !== 1'b1 && fail !== 1'b1 && n < 120000) begin
      @(negedge clk_in);
      n++;
      start_in = poke && n == 300;
    end
    check({fail, done}, nd == 0 ? 2'h2 : 2'h1);
    check(passes, exp_passes(e, l, nd));
    check(pn, exp_passes(e, l, nd));
    n = exp_passes(e, l, nd);
    check(i_flash.pulse_cyc, exp_pulse(e, l, n));
    repeat (3) @(negedge clk_in);
    check({busy, sw_en, done}, 3'h0);
    $display("test end: erase %0d long %0d need %0d passes %0d",
             e, l, nd, passes);
  endtask : run_op

  initial begin
    repeat (5) @(negedge clk_in);
    check({busy, done, fail, sw_en, su, pl, vf, dwr, vrd}, 0);
    rst_b_in = 1'b1;
    run_op(1'b0, 1'b0, 1, 1'b0);
    run_op(1'b0, 1'b0, 6, 1'b1);
    run_op(1'b1, 1'b0, 2, 1'b0);
    run_op(1'b1, 1'b1, 0, 1'b0);
    for (i = 0; i < 2; i++)
      run_op(1'($random(seed)), 1'($random(seed)),
             1 + int'({$random(seed)} % 2), 1'b0);
    stop_test();
  end

  initial begin
    #15_000_000;
    bad_count++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
